// File: shared/fdf_pkg.sv
package fdf_pkg;
	// byte offsets on the register bus
	localparam logic [7:0] FLAGS_OFS     = 8'h00;
	localparam logic [7:0] PIN_CFG_OFS   = 8'h04;
	localparam logic [7:0] RESP_CFG_OFS  = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;
	// event flag positions
	localparam int FL_TIMEOUT  = 0;
	localparam int FL_THERMAL  = 1;
	localparam int FL_LED      = 2;
	localparam int FL_SYNC1    = 3;
	localparam int FL_SYNC2    = 4;
	localparam int FL_THERM_NTC = 5;
	localparam int FL_VFLASH   = 6;
	localparam int FL_VMON     = 7;
	// pin_and_input_config fields
	localparam int PC_TORCH    = 7;
	localparam int PC_POL2     = 6;
	localparam int PC_POL1     = 5;
	localparam int PC_THERM    = 4;
	localparam int PC_STB_POL  = 3;
	localparam int PC_STB_EN   = 2;
	localparam logic [7:0] PIN_CFG_MASK   = 8'hfc;
	localparam logic [7:0] PIN_CFG_RESET  = 8'h68;
	// fault_response_config fields
	localparam int RC_VMON_SD  = 3;
	localparam int RC_EXPO     = 2;
	localparam int RC_THERM_SD = 1;
	localparam int RC_SYNC2_SD = 0;
	localparam logic [7:0] RESP_CFG_MASK  = 8'h0f;
	localparam logic [7:0] RESP_CFG_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET    = 8'h00;
	localparam logic [7:0] MASK_RESET     = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] pin_cfg;
		logic [7:0] resp_cfg;
		logic [7:0] irq_mask;
		logic       sync1_d;
		logic       sync2_d;
		logic       ph_valid;
		logic       ph_write;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
	} fdf_state_t;
endpackage : fdf_pkg

// File: logic/fdf_regs.sv
// Our own choices: the AHB-Lite slave port and the register offsets.
module fdf_regs
	import fdf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        ev_flash_timeout,
	input  wire logic        ev_thermal,
	input  wire logic        ev_led_fault,
	input  wire logic        shared_sync_torch_pin,
	input  wire logic        second_sync_input,
	input  wire logic        therm_below_trip,
	input  wire logic        supply_mon_trip,
	input  wire logic        supply_flash_trip,
	input  wire logic        flash_event,
	input  wire logic        strobe_pin,
	output logic             torch_enable,
	output logic             strobe_active,
	output logic             thermistor_mode,
	output logic             force_torch,
	output logic             force_shutdown,
	output logic             exposure_timing_mode,
	output logic             irq
);
	fdf_state_t s_r, s_nxt;

	function automatic logic [31:0] rd_mux(input fdf_state_t s,
	                                       input logic [7:0] a);
		case (a)
			FLAGS_OFS:    rd_mux = {24'h000000, s.flags};
			PIN_CFG_OFS:  rd_mux = {24'h000000, s.pin_cfg};
			RESP_CFG_OFS: rd_mux = {24'h000000, s.resp_cfg};
			IRQ_MASK_OFS: rd_mux = {24'h000000, s.irq_mask};
			default:      rd_mux = 32'h00000000;
		endcase
	endfunction : rd_mux

	logic       sync_mode1;
	logic       sync1_lvl;
	logic       sync2_lvl;
	logic       sync2_ev;
	logic       therm_ev;
	logic       vmon_ev;
	logic [7:0] set_v;
	logic       take;

	always_comb begin
		sync_mode1 = ~s_r.pin_cfg[PC_TORCH];
		// polarity normalises pins so "active" reads one
		sync1_lvl = ~(shared_sync_torch_pin ^ s_r.pin_cfg[PC_POL1]);
		sync2_lvl = ~(second_sync_input ^ s_r.pin_cfg[PC_POL2]);
		sync2_ev = sync2_lvl ^ s_r.sync2_d;
		therm_ev = s_r.pin_cfg[PC_THERM] & therm_below_trip;
		vmon_ev = supply_mon_trip;
		set_v = '0;
		set_v[FL_TIMEOUT] = ev_flash_timeout;
		set_v[FL_THERMAL] = ev_thermal;
		set_v[FL_LED] = ev_led_fault;
		set_v[FL_SYNC1] = sync_mode1 & (sync1_lvl ^ s_r.sync1_d);
		set_v[FL_SYNC2] = sync2_ev;
		set_v[FL_THERM_NTC] = therm_ev;
		set_v[FL_VFLASH] = supply_flash_trip;
		set_v[FL_VMON] = vmon_ev;
		take = hsel & hready & (htrans == HTRANS_NONSEQ);
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1_d = sync1_lvl;
		s_nxt.sync2_d = sync2_lvl;
		s_nxt.ph_valid = take;
		if (take) begin
			s_nxt.ph_write = hwrite;
			s_nxt.ph_addr = haddr[7:0];
			if (!hwrite) begin
				s_nxt.rdata = rd_mux(s_r, haddr[7:0]);
			end
		end
		// reading the flags clears them; events in the same cycle survive
		if (take && !hwrite && haddr[7:0] == FLAGS_OFS) begin
			s_nxt.flags = FLAGS_RESET;
		end
		if (s_r.ph_valid && s_r.ph_write) begin
			case (s_r.ph_addr)
				PIN_CFG_OFS:  s_nxt.pin_cfg = hwdata[7:0] & PIN_CFG_MASK;
				RESP_CFG_OFS: s_nxt.resp_cfg = hwdata[7:0] & RESP_CFG_MASK;
				IRQ_MASK_OFS: s_nxt.irq_mask = hwdata[7:0];
				// write one to clear, set still wins below
				FLAGS_OFS:    s_nxt.flags = s_nxt.flags & ~hwdata[7:0];
				default: ;
			endcase
		end
		s_nxt.flags = s_nxt.flags | set_v;
		if (flash_event) begin
			s_nxt.pin_cfg[PC_TORCH] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{flags: FLAGS_RESET, pin_cfg: PIN_CFG_RESET,
			         resp_cfg: RESP_CFG_RESET, irq_mask: MASK_RESET,
			         sync1_d: 1'b0, sync2_d: 1'b0, ph_valid: 1'b0,
			         ph_write: 1'b0, ph_addr: 8'h00, rdata: 32'h00000000};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_r.rdata;
	assign torch_enable = s_r.pin_cfg[PC_TORCH] & shared_sync_torch_pin;
	assign strobe_active = s_r.pin_cfg[PC_STB_EN] &
	                       ~(strobe_pin ^ s_r.pin_cfg[PC_STB_POL]);
	assign thermistor_mode = s_r.pin_cfg[PC_THERM];
	assign exposure_timing_mode = s_r.resp_cfg[RC_EXPO];
	// shutdown outranks torch reduction when several faults coincide
	assign force_shutdown = (sync2_ev & s_r.resp_cfg[RC_SYNC2_SD])
	                      | (therm_ev & s_r.resp_cfg[RC_THERM_SD])
	                      | (vmon_ev & s_r.resp_cfg[RC_VMON_SD]);
	assign force_torch = ~force_shutdown &
	                     ((sync2_ev & ~s_r.resp_cfg[RC_SYNC2_SD])
	                     | (therm_ev & ~s_r.resp_cfg[RC_THERM_SD])
	                     | (vmon_ev & ~s_r.resp_cfg[RC_VMON_SD]));
	assign irq = |(s_r.flags & s_r.irq_mask);
endmodule : fdf_regs

// File: dv/fdf_chk.sv
module fdf_chk
	import fdf_pkg::*;
(
	input wire logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp,
	input wire logic [1:0] htrans,
	input wire logic [31:0] hrdata,
	input wire logic shared_sync_torch_pin, second_sync_input,
	input wire logic therm_below_trip, supply_mon_trip, supply_flash_trip,
	input wire logic flash_event, torch_enable, force_torch, force_shutdown,
	input wire logic thermistor_mode, exposure_timing_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic wr;
	// config moves two edges after the write's address phase
	assign wr = hsel && hready && hwrite && htrans == HTRANS_NONSEQ;
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");
	AST_HI_ZERO: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read data set");
	AST_TORCH_PIN: assert property (torch_enable |-> shared_sync_torch_pin)
		else $error("torch without pin");
	AST_TORCH_CLR: assert property (flash_event |=> !torch_enable)
		else $error("torch kept after flash");
	AST_FORCE_EXCL: assert property (!(force_torch && force_shutdown))
		else $error("torch and shutdown together");
	AST_FORCE_CAUSE: assert property ((force_torch || force_shutdown) |->
		$changed(second_sync_input) || therm_below_trip || supply_mon_trip
		|| supply_flash_trip) else $error("force without cause");
	AST_THERM_MODE: assert property ($changed(thermistor_mode) |->
		$past(wr, 2)) else $error("thermistor mode moved alone");
	AST_EXPO_MODE: assert property ($changed(exposure_timing_mode) |->
		$past(wr, 2)) else $error("exposure mode moved alone");
endmodule : fdf_chk

bind fdf_regs fdf_chk i_fdf_chk (.*);

// File: dv/fdf_host.sv
module fdf_host
	import fdf_pkg::*;
(
	input wire logic clk, hready,
	input wire logic [31:0] hrdata,
	output logic hsel, hwrite,
	output logic [1:0] htrans,
	output logic [31:0] haddr, hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {hsel, hwrite, htrans, haddr, hwdata} = '0;
	// waits on hready, so any slave latency is accepted
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
endmodule : fdf_host

// File: dv/tb_top.sv
module tb_top;
	import fdf_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, hsel, hwrite, rdy, hresp, irq, tor, stb, thm, ft, fs, ex;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [9:0] ev;
	int n_mismatch, checked;
	fdf_host i_fdf_host (.clk(clk), .hready(rdy), .hrdata(hrdata), .hsel(hsel),
		.hwrite(hwrite), .htrans(htrans), .haddr(haddr), .hwdata(hwdata));
	fdf_regs i_fdf_regs (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(rdy), .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata),
		.ev_flash_timeout(ev[0]), .ev_thermal(ev[1]), .ev_led_fault(ev[2]),
		.shared_sync_torch_pin(ev[3]), .second_sync_input(ev[4]),
		.therm_below_trip(ev[5]), .supply_flash_trip(ev[6]),
		.supply_mon_trip(ev[7]), .flash_event(ev[8]), .strobe_pin(ev[9]),
		.torch_enable(tor), .strobe_active(stb), .thermistor_mode(thm),
		.force_torch(ft), .force_shutdown(fs), .exposure_timing_mode(ex),
		.irq(irq));
	task automatic chk(input string s, input logic [31:0] v, e);
		checked++;
		if (v !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_fdf_host.xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_fdf_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic pulse(input int i);
		@(posedge clk) ev[i] <= 1'b1;
		@(posedge clk) ev[i] <= 1'b0;
		#1;
	endtask : pulse
	task automatic end_sim;
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#20us;
		n_mismatch++;
		end_sim();
	end
	initial begin
		nrst = 1'b0;
		ev = 10'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd(PIN_CFG_OFS, 32'h68);
		rd(RESP_CFG_OFS, 32'h0);
		pulse(0);
		chk("irq", irq, 32'h0);
		rd(FLAGS_OFS, 32'h1);
		rd(FLAGS_OFS, 32'h0);
		wr(PIN_CFG_OFS, 32'hff);
		wr(RESP_CFG_OFS, 32'hff);
		rd(PIN_CFG_OFS, 32'hfc);
		rd(RESP_CFG_OFS, 32'h0f);
		rd(8'h10, 32'h0);
		chk("modes", {thm, ex}, 32'h3);
		@(posedge clk) ev[9] <= 1'b1;
		#1 chk("strobe", stb, 32'h1);
		pulse(8);
		rd(PIN_CFG_OFS, 32'h7c);
		wr(IRQ_MASK_OFS, 32'hff);
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			chk("irq", irq, 32'h1);
			rd(FLAGS_OFS, 32'h1 << i);
			rd(FLAGS_OFS, 32'h0);
		end
		// shared pin in torch role drives torch_enable and sets no flag
		wr(PIN_CFG_OFS, 32'hfc);
		@(posedge clk) ev[3] <= 1'b1;
		#1 chk("torch", tor, 32'h1);
		@(posedge clk) ev[3] <= 1'b0;
		#1 chk("torch off", tor, 32'h0);
		rd(FLAGS_OFS, 32'h0);
		wr(RESP_CFG_OFS, 32'h0);
		@(posedge clk) ev[4] <= 1'b1;
		#1 chk("force torch", {ft, fs}, 32'h2);
		@(posedge clk) ev[4] <= 1'b0;
		wr(RESP_CFG_OFS, 32'h1);
		@(posedge clk) ev[4] <= 1'b1;
		#1 chk("force shutdown", {ft, fs}, 32'h1);
		@(posedge clk) ev[4] <= 1'b0;
		#1 chk("irq pending", irq, 32'h1);
		wr(FLAGS_OFS, 32'h10);
		#1 chk("irq cleared", irq, 32'h0);
		rd(FLAGS_OFS, 32'h0);
		end_sim();
	end
endmodule : tb_top
